//--- inc/long_branch_pkg.sv
// shared constants, types and register map for the long branch condition unit
package long_branch_pkg;

    // ====================================================================
    // encoding
    localparam logic [7:0] PREFIX_BYTE = 8'h18;
    localparam logic [3:0] OP_GROUP = 4'h2;
    localparam logic [7:0] OP_ALWAYS = 8'h20;
    localparam logic [7:0] OP_NEVER = 8'h21;
    localparam logic [7:0] OP_UNS_HIGHER = 8'h22;
    localparam logic [7:0] OP_UNS_LOWER_SAME = 8'h23;
    localparam logic [7:0] OP_CARRY_CLEAR = 8'h24;
    localparam logic [7:0] OP_CARRY_SET = 8'h25;
    localparam logic [7:0] OP_NOT_EQUAL = 8'h26;
    localparam logic [7:0] OP_EQUAL = 8'h27;
    localparam logic [7:0] OP_NO_OVERFLOW = 8'h28;
    localparam logic [7:0] OP_ON_OVERFLOW = 8'h29;
    localparam logic [7:0] OP_POSITIVE = 8'h2a;
    localparam logic [7:0] OP_NEGATIVE = 8'h2b;
    localparam logic [7:0] OP_SIGNED_GE = 8'h2c;
    localparam logic [7:0] OP_SIGNED_LT = 8'h2d;
    localparam logic [7:0] OP_SIGNED_GT = 8'h2e;
    localparam logic [7:0] OP_SIGNED_LE = 8'h2f;

    // ====================================================================
    // timing and program counter step
    localparam int TAKEN_CYCLES = 4;
    localparam int NOT_TAKEN_CYCLES = 3;
    localparam logic [15:0] PC_STEP = 16'h0004;

    // ====================================================================
    // register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_TAKEN_CNT = 8'h08;
    localparam logic [7:0] REG_NOT_TAKEN_CNT = 8'h0c;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_TAKEN_BIT = 1;
    localparam int STATUS_BAD_BIT = 2;

    // ====================================================================
    // types
    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } flags_t;

    typedef struct packed {
        logic [7:0] prefix;
        logic [7:0] opcode;
        logic [7:0] offHigh;
        logic [7:0] offLow;
    } insn_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } state_t;

endpackage

//--- core/branch_cond.sv
// opcode decode and flag test for the prefixed long branch family
`timescale 1ns/1ns
`default_nettype none

module branch_cond (
    // instruction bytes
    input wire logic [7:0] prefix,
    input wire logic [7:0] opcode,
    // condition codes
    input wire long_branch_pkg::flags_t flags,
    // result
    output logic isLongBranch,
    output logic condMet
);

    // ====================================================================
    // even opcode gives the base test, the odd one its complement
    function automatic logic evalCond(input logic [7:0] op, input long_branch_pkg::flags_t f);
        logic base;
        base = 1'b0;
        case ({op[7:1], 1'b0})
            long_branch_pkg::OP_ALWAYS: base = 1'b1; // RULE_15
            long_branch_pkg::OP_UNS_HIGHER: base = !(f.c | f.z); // RULE_10
            long_branch_pkg::OP_CARRY_CLEAR: base = !f.c; // RULE_11
            long_branch_pkg::OP_NOT_EQUAL: base = !f.z; // RULE_12
            long_branch_pkg::OP_NO_OVERFLOW: base = !f.v; // RULE_01 RULE_14
            long_branch_pkg::OP_POSITIVE: base = !f.n; // RULE_13
            long_branch_pkg::OP_SIGNED_GE: base = !(f.n ^ f.v); // RULE_09
            long_branch_pkg::OP_SIGNED_GT: base = !(f.z | (f.n ^ f.v)); // RULE_08
            default: base = 1'b0;
        endcase
        return base ^ op[0];
    endfunction

    // only prefix plus 0x2n belongs to this family
    assign isLongBranch = (prefix == long_branch_pkg::PREFIX_BYTE) && (opcode[7:4] == long_branch_pkg::OP_GROUP); // RULE_04
    assign condMet = isLongBranch && evalCond(opcode, flags);

endmodule
`default_nettype wire

//--- core/target_calc.sv
// next program counter: step past the four bytes, plus offset when taken
`timescale 1ns/1ns
`default_nettype none

module target_calc (
    // operands
    input wire logic [15:0] insAddr,
    input wire logic [15:0] offset,
    input wire logic taken,
    // result
    output logic [15:0] target
);

    // ====================================================================
    // 16-bit wrap is intended: a two's complement offset reaches back
    wire logic [15:0] stepped;
    assign stepped = insAddr + long_branch_pkg::PC_STEP; // RULE_02
    assign target = taken ? stepped + offset : stepped; // RULE_02 RULE_03

endmodule
`default_nettype wire

//--- core/long_branch_condition_unit.sv
// long relative branch decode, condition test, cycle sequencing and apb status
`timescale 1ns/1ns
`default_nettype none

// ========================================================================
// Contract
// (RULE_01) the no-overflow branch is taken only when the overflow flag is 0.
// (RULE_02) taken: pc becomes address plus 4 plus offset; not taken: address plus 4.
// (RULE_03) the offset is a 16-bit two's complement word from the third and fourth bytes.
// (RULE_04) the no-overflow branch is the bytes 0x18, 0x28, offset high, offset low.
// (RULE_05) a taken conditional branch lasts four cycles and refills the queue.
// (RULE_06) a not-taken conditional branch lasts three cycles with no refill.
// (RULE_07) no long branch alters any condition code flag.
// (RULE_08) 0x2e branches when z or (n xor v) is 0, 0x2f when it is 1.
// (RULE_09) 0x2c branches when n xor v is 0, 0x2d when it is 1.
// (RULE_10) 0x22 branches when c or z is 0, 0x23 when it is 1.
// (RULE_11) 0x24 branches when carry is 0, 0x25 when it is 1.
// (RULE_12) 0x27 branches when zero is 1, 0x26 when it is 0.
// (RULE_13) 0x2b branches when negative is 1, 0x2a when it is 0.
// (RULE_14) 0x29 branches when overflow is 1, the complement of 0x28.
// (RULE_15) 0x20 always branches and 0x21 never does.

module long_branch_condition_unit #(
    parameter int CNT_W = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction queue
    input wire logic insValid,
    output logic insReady,
    input wire long_branch_pkg::insn_t insBytes,
    input wire logic [15:0] insAddr,
    // condition codes
    input wire long_branch_pkg::flags_t ccrIn,
    output long_branch_pkg::flags_t ccrOut,
    // program counter side
    output logic [15:0] pcNext,
    output logic branchTaken,
    output logic refillReq,
    output logic execDone,
    output logic badOpcode
);

    localparam logic [CNT_W-1:0] TAKEN_LOAD = CNT_W'(long_branch_pkg::TAKEN_CYCLES - 1);
    localparam logic [CNT_W-1:0] NOT_TAKEN_LOAD = CNT_W'(long_branch_pkg::NOT_TAKEN_CYCLES - 1);

    long_branch_pkg::state_t stateReg;
    long_branch_pkg::state_t stateNext;
    logic [CNT_W-1:0] cntReg;
    logic [CNT_W-1:0] cntNext;
    logic startReg;
    logic takenReg;
    logic badReg;
    logic [15:0] pcReg;
    logic [15:0] addrReg;
    logic [15:0] offReg;
    logic [7:0] opReg;
    long_branch_pkg::flags_t ccrReg;
    logic enableReg;
    logic [31:0] takenCntReg;
    logic [31:0] notTakenCntReg;
    logic [31:0] prdataReg;
    logic pslverrReg;

    // ====================================================================
    // decode and target
    wire logic isLong;
    wire logic condMet;
    wire logic [15:0] offWord;
    wire logic [15:0] target;

    assign offWord = {insBytes.offHigh, insBytes.offLow}; // RULE_03

    branch_cond u_cond (
        .prefix(insBytes.prefix),
        .opcode(insBytes.opcode),
        .flags(ccrIn),
        .isLongBranch(isLong),
        .condMet(condMet)
    );

    target_calc u_target (
        .insAddr(insAddr),
        .offset(offWord),
        .taken(condMet),
        .target(target)
    );

    // ====================================================================
    // sequencing
    wire logic insFire;
    wire logic goodFire;
    wire logic lastCycle;

    // one instruction at a time; a disabled unit refuses the queue
    assign insReady = (stateReg == long_branch_pkg::ST_IDLE) && enableReg;
    assign insFire = insValid && insReady;
    assign goodFire = insFire && isLong; // RULE_04
    assign lastCycle = (stateReg == long_branch_pkg::ST_EXEC) && (cntReg == '0);
    // taken runs four cycles, not taken three
    assign cntNext = goodFire ? (condMet ? TAKEN_LOAD : NOT_TAKEN_LOAD) : // RULE_05 RULE_06
        ((cntReg != '0) ? cntReg - CNT_W'(1) : cntReg);

    // state transitions
    always_comb begin
        stateNext = stateReg;
        case (stateReg)
            long_branch_pkg::ST_IDLE: begin
                if (goodFire) begin
                    stateNext = long_branch_pkg::ST_EXEC;
                end
            end
            long_branch_pkg::ST_EXEC: begin
                if (lastCycle) begin
                    stateNext = long_branch_pkg::ST_IDLE;
                end
            end
            default: stateNext = long_branch_pkg::ST_IDLE;
        endcase
    end

    // state and cycle count
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stateReg <= long_branch_pkg::ST_IDLE;
            cntReg <= '0;
            startReg <= 1'b0;
            badReg <= 1'b0;
        end else begin
            stateReg <= stateNext;
            cntReg <= cntNext;
            startReg <= goodFire;
            badReg <= insFire && !isLong; // RULE_04
        end
    end

    // instruction capture; flags are carried through untouched
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            takenReg <= 1'b0;
            pcReg <= '0;
            addrReg <= '0;
            offReg <= '0;
            opReg <= '0;
            ccrReg <= '0;
        end else if (goodFire) begin
            takenReg <= condMet; // RULE_01
            pcReg <= target; // RULE_02
            addrReg <= insAddr;
            offReg <= offWord; // RULE_03
            opReg <= insBytes.opcode;
            ccrReg <= ccrIn; // RULE_07
        end
    end

    // queue refill only on the first cycle of a taken branch
    assign refillReq = startReg && takenReg; // RULE_05 RULE_06
    assign execDone = lastCycle;
    assign badOpcode = badReg;
    assign branchTaken = takenReg;
    assign pcNext = pcReg;
    assign ccrOut = ccrReg; // RULE_07

    // ====================================================================
    // apb register file, zero wait states
    wire logic setupPhase;
    wire logic wrAccess;
    wire logic selCtrl;
    wire logic selStatus;
    wire logic selTaken;
    wire logic selNotTaken;
    wire logic mapped;
    wire logic [31:0] statusWord;
    wire logic [31:0] rdMux;
    wire logic incTaken;
    wire logic incNotTaken;

    assign setupPhase = psel && !penable;
    assign wrAccess = psel && penable && pwrite;
    assign selCtrl = (paddr == long_branch_pkg::REG_CTRL);
    assign selStatus = (paddr == long_branch_pkg::REG_STATUS);
    assign selTaken = (paddr == long_branch_pkg::REG_TAKEN_CNT);
    assign selNotTaken = (paddr == long_branch_pkg::REG_NOT_TAKEN_CNT);
    assign mapped = selCtrl || selStatus || selTaken || selNotTaken;
    assign statusWord = {29'h0, badReg, takenReg, stateReg == long_branch_pkg::ST_EXEC};
    assign rdMux = selCtrl ? {31'h0, enableReg} :
        selStatus ? statusWord :
        selTaken ? takenCntReg :
        selNotTaken ? notTakenCntReg : 32'h0;
    assign incTaken = goodFire && condMet;
    assign incNotTaken = goodFire && !condMet;
    assign pready = 1'b1;
    assign prdata = prdataReg;
    assign pslverr = pslverrReg;

    // read data is sampled in the setup cycle so prdata comes from a flop
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdataReg <= '0;
            pslverrReg <= 1'b0;
        end else if (setupPhase) begin
            prdataReg <= pwrite ? 32'h0 : rdMux;
            pslverrReg <= !mapped;
        end
    end

    // control write; the enable gates the queue handshake
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            enableReg <= long_branch_pkg::CTRL_ENABLE_RESET;
        end else if (wrAccess && selCtrl) begin
            enableReg <= pwdata[long_branch_pkg::CTRL_ENABLE_BIT];
        end
    end

    // outcome counters: a write to a counter's own address clears it, but a same-cycle count is kept
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            takenCntReg <= '0;
            notTakenCntReg <= '0;
        end else begin
            if (wrAccess && selTaken) begin
                takenCntReg <= {31'h0, incTaken};
            end else if (incTaken) begin
                takenCntReg <= takenCntReg + 32'h1;
            end
            if (wrAccess && selNotTaken) begin
                notTakenCntReg <= {31'h0, incNotTaken};
            end else if (incNotTaken) begin
                notTakenCntReg <= notTakenCntReg + 32'h1;
            end
        end
    end

    // ====================================================================
    // checks
    wire logic [7:0] opPair;
    wire logic clrTaken;
    wire logic clrNotTaken;
    assign opPair = {opReg[7:1], 1'b0};
    assign clrTaken = wrAccess && selTaken;
    assign clrNotTaken = wrAccess && selNotTaken;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    AST_NO_OVF_TEST: assert property ( // RULE_01
        startReg && opReg == long_branch_pkg::OP_NO_OVERFLOW |-> takenReg == !ccrReg.v)
        else $error("no-overflow branch decision wrong");
    AST_TAKEN_TARGET: assert property ( // RULE_02
        startReg && takenReg |-> 16'(pcNext - offReg) == 16'(addrReg + long_branch_pkg::PC_STEP))
        else $error("taken target wrong");
    AST_STEP_TARGET: assert property ( // RULE_02
        startReg && !takenReg |-> pcNext == 16'(addrReg + long_branch_pkg::PC_STEP))
        else $error("fall-through address wrong");
    AST_OFFSET_ORDER: assert property ( // RULE_03
        goodFire |=> offReg[15:8] == $past(insBytes.offHigh) && offReg[7:0] == $past(insBytes.offLow))
        else $error("offset bytes not high then low");
    AST_BAD_PREFIX: assert property ( // RULE_04
        insFire && insBytes.prefix != long_branch_pkg::PREFIX_BYTE |=>
            badOpcode && stateReg == long_branch_pkg::ST_IDLE)
        else $error("non-prefixed opcode started execution");
    AST_TAKEN_FOUR: assert property ( // RULE_05
        startReg && takenReg |-> refillReq && !execDone ##1 !execDone [*2] ##1 execDone)
        else $error("taken branch not four cycles");
    AST_NOT_TAKEN_THREE: assert property ( // RULE_06
        startReg && !takenReg |-> !refillReq && !execDone ##1 !execDone ##1 execDone)
        else $error("not-taken branch not three cycles");
    AST_FLAGS_KEPT: assert property ( // RULE_07
        goodFire |=> ccrOut == $past(ccrIn) ##1 $stable(ccrOut))
        else $error("flags changed by branch");
    AST_SIGNED_GT_LE: assert property ( // RULE_08
        startReg && opPair == long_branch_pkg::OP_SIGNED_GT |->
            takenReg == (opReg[0] ^ !(ccrReg.z | (ccrReg.n ^ ccrReg.v))))
        else $error("signed greater test wrong");
    AST_SIGNED_GE_LT: assert property ( // RULE_09
        startReg && opPair == long_branch_pkg::OP_SIGNED_GE |->
            takenReg == (opReg[0] ^ !(ccrReg.n ^ ccrReg.v)))
        else $error("signed greater-equal test wrong");
    AST_UNSIGNED_HI_LS: assert property ( // RULE_10
        startReg && opPair == long_branch_pkg::OP_UNS_HIGHER |->
            takenReg == (opReg[0] ^ !(ccrReg.c | ccrReg.z)))
        else $error("unsigned higher test wrong");
    AST_CARRY: assert property ( // RULE_11
        startReg && opPair == long_branch_pkg::OP_CARRY_CLEAR |-> takenReg == (opReg[0] ~^ ccrReg.c))
        else $error("carry test wrong");
    AST_ZERO: assert property ( // RULE_12
        startReg && opPair == long_branch_pkg::OP_NOT_EQUAL |-> takenReg == (opReg[0] ~^ ccrReg.z))
        else $error("zero test wrong");
    AST_NEGATIVE: assert property ( // RULE_13
        startReg && opPair == long_branch_pkg::OP_POSITIVE |-> takenReg == (opReg[0] ~^ ccrReg.n))
        else $error("negative test wrong");
    AST_ON_OVF: assert property ( // RULE_14
        startReg && opReg == long_branch_pkg::OP_ON_OVERFLOW |-> takenReg == ccrReg.v)
        else $error("overflow-set branch decision wrong");
    AST_ALWAYS_NEVER: assert property ( // RULE_15
        startReg && opPair == long_branch_pkg::OP_ALWAYS |-> takenReg == !opReg[0])
        else $error("always or never branch wrong");

    // the queue side only looks at execDone, so these guard the cycles in between
    AST_DONE_REFUSES: assert property ( // RULE_05
        execDone |-> !insReady)
        else $error("queue accepted in the done cycle");
    AST_DONE_PULSE: assert property ( // RULE_05
        execDone |=> !execDone && stateReg == long_branch_pkg::ST_IDLE)
        else $error("done not a single pulse");
    AST_REFILL_TAKEN_ONLY: assert property ( // RULE_06
        refillReq |-> branchTaken && stateReg == long_branch_pkg::ST_EXEC)
        else $error("refill without a taken branch");
    AST_PC_HELD: assert property ( // RULE_02
        stateReg == long_branch_pkg::ST_EXEC && !startReg |-> $stable(pcNext))
        else $error("next pc moved during execution");
    AST_FLAGS_HELD: assert property ( // RULE_07
        stateReg == long_branch_pkg::ST_EXEC && !startReg |-> $stable(ccrOut) && $stable(branchTaken))
        else $error("flags moved during execution");
    AST_BAD_NOT_RUN: assert property ( // RULE_04
        badOpcode |-> stateReg == long_branch_pkg::ST_IDLE && !refillReq && !execDone)
        else $error("refused word started execution");

    // outcome counters; a clear in the same cycle leaves the new count at one
    AST_COUNT_TAKEN: assert property ( // RULE_05
        incTaken |=> takenCntReg == ($past(clrTaken) ? 32'h1 : $past(takenCntReg) + 32'h1))
        else $error("taken counter missed a branch");
    AST_COUNT_NOT_TAKEN: assert property ( // RULE_06
        incNotTaken |=> notTakenCntReg == ($past(clrNotTaken) ? 32'h1 : $past(notTakenCntReg) + 32'h1))
        else $error("not-taken counter missed a branch");

    // main scenarios
    COV_TAKEN: cover property (startReg && takenReg ##3 execDone);
    COV_NOT_TAKEN: cover property (startReg && !takenReg ##2 execDone);
    COV_BAD: cover property (badOpcode);
    COV_BACK_TO_BACK: cover property (execDone ##2 startReg);
    COV_HELD_OFF: cover property (insValid && !enableReg);

endmodule
`default_nettype wire

//--- dv/ins_queue_model.sv
// instruction queue model that offers prefixed branch words to the unit
`timescale 1ns/1ns
`default_nettype none

module ins_queue_model (
    // clock
    input wire logic ref_clk,
    // queue handshake
    input wire logic insReady,
    output logic insValid,
    output long_branch_pkg::insn_t insBytes,
    output logic [15:0] insAddr,
    output long_branch_pkg::flags_t ccrIn
);
    // ====================================================================
    // idle lines at time zero
    initial begin
        insValid = 1'b0;
        insBytes = 32'h0;
        insAddr = 16'h0;
        ccrIn = 4'h0;
    end

    // ====================================================================
    // offer one word after a gap of at least one edge, hold it until taken;
    // released lines carry the inverse so stale values never look valid
    task automatic offer(input long_branch_pkg::insn_t w, input logic [15:0] a, input logic [3:0] f,
                         input int gap);
        repeat (gap) @(posedge ref_clk);
        insValid <= 1'b1;
        insBytes <= w;
        insAddr <= a;
        ccrIn <= f;
        @(posedge ref_clk);
        while (insReady !== 1'b1) @(posedge ref_clk);
        insValid <= 1'b0;
        insBytes <= ~w;
        insAddr <= ~a;
        ccrIn <= ~f;
    endtask
endmodule

`default_nettype wire

//--- dv/test_long_branch_condition_unit.sv
// self-checking bench for the long branch condition unit
`timescale 1ns/1ns
`default_nettype none

module test_long_branch_condition_unit;
    typedef struct packed {
        logic bad;
        logic tk;
        logic [15:0] pc;
        logic [3:0] fl;
    } note_t;

    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, insValid, insReady, branchTaken, refillReq, execDone, badOpcode;
    long_branch_pkg::insn_t insBytes;
    logic [15:0] insAddr, pcNext;
    long_branch_pkg::flags_t ccrIn, ccrOut;
    int fail_count = 0;
    int tests_run = 0;
    int seed = 35480;
    int cycles = 0;
    int cyc = 0;
    logic refSeen = 1'b0;
    logic [31:0] rd;
    logic err;
    note_t notes[$];

    // ====================================================================
    // clock, unit and queue model
    always #5 ref_clk = ~ref_clk;

    long_branch_condition_unit #(.CNT_W(2)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .insValid(insValid), .insReady(insReady),
        .insBytes(insBytes), .insAddr(insAddr), .ccrIn(ccrIn), .ccrOut(ccrOut), .pcNext(pcNext),
        .branchTaken(branchTaken), .refillReq(refillReq), .execDone(execDone), .badOpcode(badOpcode));

    ins_queue_model Q (.ref_clk(ref_clk), .insReady(insReady), .insValid(insValid),
        .insBytes(insBytes), .insAddr(insAddr), .ccrIn(ccrIn));

    // ====================================================================
    // helpers
    task automatic results();
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // even opcodes test the plain condition, odd ones its complement
    function automatic logic cond(input logic [3:0] op, input logic [3:0] f);
        logic n, z, v, c, e;
        {n, z, v, c} = f;
        case (op[3:1])
            3'd0: e = 1'b1;
            3'd1: e = ~(c | z);
            3'd2: e = ~c;
            3'd3: e = ~z;
            3'd4: e = ~v;
            3'd5: e = ~n;
            3'd6: e = ~(n ^ v);
            default: e = ~(z | (n ^ v));
        endcase
        return op[0] ? ~e : e;
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // note the expected outcome, then hand the word to the queue model
    task automatic send(input logic [7:0] p, input logic [7:0] o, input logic [3:0] f,
                        input logic [15:0] a, input logic [15:0] off);
        note_t n;
        n.bad = !(p == 8'h18 && o[7:4] == 4'h2);
        n.tk = cond(o[3:0], f);
        n.pc = a + 16'h0004 + (n.tk ? off : 16'h0000);
        n.fl = f;
        notes.push_back(n);
        Q.offer({p, o, off}, a, f, 1 + ($random(seed) & 1));
    endtask

    task automatic drain();
        for (int i = 0; i < 50 && notes.size() > 0; i++) @(posedge ref_clk);
        chk(32'(notes.size()), 32'h0);
        repeat (2) @(posedge ref_clk);
    endtask

    // ====================================================================
    // ceiling on the whole run; the full sweep needs only about 1150 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end

    // result watcher: pairs each result pulse with the oldest note
    always @(posedge ref_clk) begin
        note_t n;
        cyc++;
        if (insValid && insReady) begin
            cyc = 0;
            refSeen = 1'b0;
        end
        if (refillReq === 1'b1) refSeen = 1'b1;
        if (execDone === 1'b1 || badOpcode === 1'b1) begin
            if (notes.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                n = notes.pop_front();
                chk(32'(badOpcode), 32'(n.bad));
                if (!n.bad) begin
                    chk(32'(pcNext), 32'(n.pc));
                    chk(32'(branchTaken), 32'(n.tk));
                    chk(32'(ccrOut), 32'(n.fl));
                    chk(32'(cyc), n.tk ? 32'd4 : 32'd3);
                    chk(32'(refSeen), 32'(n.tk));
                end
            end
        end
    end

    // ====================================================================
    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        apb(1'b0, long_branch_pkg::REG_CTRL, 32'h0);
        chk(32'(rd[0]), 32'h1);
        apb(1'b0, long_branch_pkg::REG_STATUS, 32'h0);
        chk(32'(rd[2:0]), 32'h0);
        apb(1'b1, 8'h10, 32'hffffffff);
        chk(32'(err), 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, long_branch_pkg::REG_TAKEN_CNT, 32'h0);
        apb(1'b1, long_branch_pkg::REG_NOT_TAKEN_CNT, 32'h0);
        send(8'h18, 8'h20, 4'hf, 16'h1000, 16'hfffc);
        send(8'h18, 8'h21, 4'h0, 16'h2000, 16'h0010);
        send(8'h18, 8'h21, 4'h5, 16'h3000, 16'h0010);
        drain();
        apb(1'b0, long_branch_pkg::REG_TAKEN_CNT, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, long_branch_pkg::REG_NOT_TAKEN_CNT, 32'h0);
        chk(rd, 32'h2);
        // every opcode against every flag pattern, random addresses and offsets
        for (int op = 0; op < 16; op++) begin
            for (int f = 0; f < 16; f++) begin
                send(8'h18, {4'h2, 4'(op)}, 4'(f), 16'($random(seed)), 16'($random(seed)));
            end
        end
        // offset extremes with address wrap
        send(8'h18, 8'h28, 4'h0, 16'hfffe, 16'h8000);
        send(8'h18, 8'h28, 4'h0, 16'hfff0, 16'h7fff);
        send(8'h18, 8'h28, 4'h2, 16'h0100, 16'h7fff);
        // words outside the family are refused, the next one still runs
        send(8'h18, 8'h30, 4'h0, 16'h0200, 16'h0004);
        send(8'h19, 8'h28, 4'h0, 16'h0300, 16'h0004);
        send(8'h18, 8'h29, 4'h2, 16'h0400, 16'hff00);
        drain();
        // status shows the last decision: taken, idle, no refused word
        apb(1'b0, long_branch_pkg::REG_STATUS, 32'h0);
        chk(32'(rd[2:0]), 32'h2);
        // a disabled unit holds the offer off until enabled again
        apb(1'b1, long_branch_pkg::REG_CTRL, 32'h0);
        fork
            send(8'h18, 8'h28, 4'h0, 16'h0500, 16'h0040);
            begin
                repeat (4) @(posedge ref_clk);
                chk(32'(insReady), 32'h0);
                chk(32'(notes.size()), 32'h1);
                apb(1'b1, long_branch_pkg::REG_CTRL, 32'h1);
            end
        join
        drain();
        results();
    end
endmodule

`default_nettype wire
